/* fault_status_defines.vh */
`ifndef FAULT_STATUS_DEFINES_VH
`define FAULT_STATUS_DEFINES_VH

// Serial frame lengths, with and without the check byte
`define FRAME_BITS       6'd24
`define FRAME_BITS_PEC   6'd32
`define CRC_POLY         8'h07
`define CRC_INIT         8'h00

// Command word fields
`define CMD_RW_BIT       23
`define CMD_DUT_HI       22
`define CMD_DUT_LO       21
`define CMD_ADDR_HI      20
`define CMD_ADDR_LO      16

// Read address codes
`define RD_STATUS        5'h18
`define RD_MAIN_CTRL     5'h19

// Write address codes
`define WR_MAIN_CTRL     5'h19
`define WR_SOFTWARE      5'h1C

// Field positions in written data
`define MAIN_STATUS_ON_WRITE_ENABLE_BIT 12
`define SOFT_TOGGLE_BIT   12

// Status word layout
`define ST_BOOST_HI      15
`define ST_BOOST_LO      12
`define ST_TOGGLE        11
`define ST_PEC           10
`define ST_RAMP          9
`define ST_OVERTEMP      8
`define ST_LOOP_HI       3
`define ST_LOOP_LO       0

// Reset values
`define MAIN_CTRL_RESET  16'h0000
`define SOFT_RESET       1'b0

`endif

/* sync_stage.v */
`timescale 1ns/100ps

module sync_stage #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* fault_status_reporting.v */
// What this block does
// - Status word is read-only; only the detectors, the software toggle, a failed packet check and a status read, which clears bit 10, change it.
// - Bits 15..12 flag boost compliance loss on channels D, C, B, A.
// - A set boost compliance flag also sets that channel's loop fault bit.
// - Bit 11 mirrors the user toggle written via the software register.
// - Bit 10 flags a failed packet check on any word received since the status was last read.
// - Bit 9 is high while any channel is digitally slewing.
// - Bit 8 set when the overheat detector reports core above about 150 C.
// - Bits 3..0 flag output loop faults on D, C, B, A; bits 7..4 zero.
// - With status-on-write enabled, status shifts out on SDO during every frame that does not serve a pending read.
// - With it clear, status is returned through the normal readback sequence.
// - Fault output is active low, open drain, for a shared pull-up.
// - Fault asserts while any loop, packet check or overheat source is present.
// - Compliance fault comes from the analog headroom detector, under 1 V left.
// - A failed packet check on a received frame asserts the fault output.
// - Core overheat above about 150 C asserts the fault output.
// - Reading the status clears the packet error bit; fault then may release.
// - Status-on-write enable is clear after reset.
// - A read request's register is shifted out during the next transfer.
`timescale 1ns/100ps

`include "fault_status_defines.vh"

module fault_status_reporting #(
  parameter [1:0] DEVICE_ADDR = 2'b00
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       sclk,
  input  wire       sync_n,
  input  wire       sdin,
  output reg        sdo,
  input  wire [3:0] loop_fault,
  input  wire [3:0] boost_limit_flag,
  input  wire       overheat,
  input  wire       slew_active,
  output reg        fault_out,
  output reg        fault_oe,
  output reg        status_on_write_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  wire [2:0] pins_s;
  wire [3:0] loop_s;
  wire [3:0] boost_s;
  wire       overheat_s;
  wire       sclk_s;
  wire       sync_n_s;
  wire       sdin_s;

  // Idle-high pins travel inverted so the zero reset of the stages reads as idle,
  // otherwise a false frame start and sclk edge would follow every reset
  assign sclk_s   = ~pins_s[2];
  assign sync_n_s = ~pins_s[1];
  assign sdin_s   = pins_s[0];

  sync_stage #(.WIDTH(3)) u_pin_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({~sclk, ~sync_n, sdin}),
    .sync_out (pins_s)
  );

  sync_stage #(.WIDTH(9)) u_fault_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({loop_fault, boost_limit_flag, overheat}),
    .sync_out ({loop_s, boost_s, overheat_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the sampled link

  reg sclk_d_r;
  reg sync_n_d_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_d_r   <= 1'b1;
      sync_n_d_r <= 1'b1;
    end else begin
      sclk_d_r   <= sclk_s;
      sync_n_d_r <= sync_n_s;
    end
  end

  wire frame_start = sync_n_d_r & ~sync_n_s;
  wire frame_end   = ~sync_n_d_r & sync_n_s;
  wire in_frame    = ~sync_n_s;
  wire sclk_fall   = sclk_d_r & ~sclk_s & in_frame;
  wire sclk_rise   = ~sclk_d_r & sclk_s & in_frame;

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  reg         toggle_r;
  reg         pec_err_r;
  reg  [15:0] main_ctrl_r;
  wire [3:0]  loop_bits = loop_s | boost_s;
  wire [15:0] status_word;

  assign status_word = {boost_s, toggle_r, pec_err_r, slew_active, overheat_s,
                        4'h0, loop_bits};

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive and packet check

  reg [31:0] rx_r;
  reg [5:0]  bit_cnt_r;
  reg [7:0]  crc_r;
  wire       crc_fb = crc_r[7] ^ sdin_s;
  wire [7:0] crc_nxt = {crc_r[6:0], 1'b0} ^ (crc_fb ? `CRC_POLY : 8'h00);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_r      <= 32'h00000000;
      bit_cnt_r <= 6'h00;
      crc_r     <= `CRC_INIT;
    end else if (frame_start) begin
      bit_cnt_r <= 6'h00;
      crc_r     <= `CRC_INIT;
    end else if (sclk_fall) begin
      rx_r <= {rx_r[30:0], sdin_s};
      if (bit_cnt_r != 6'h3F) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
      if (bit_cnt_r < `FRAME_BITS) begin
        crc_r <= crc_nxt;
      end
    end
  end

  // Command sits in the low 24 bits or, with a check byte, above it
  wire        len_plain = (bit_cnt_r == `FRAME_BITS);
  wire        len_pec   = (bit_cnt_r == `FRAME_BITS_PEC);
  wire [23:0] cmd       = len_pec ? rx_r[31:8] : rx_r[23:0];
  // check byte compared at frame end
  wire        pec_fail  = frame_end & len_pec & (rx_r[7:0] != crc_r);
  wire        cmd_ok    = frame_end & (len_plain | (len_pec & ~pec_fail)) &
                          (cmd[`CMD_DUT_HI:`CMD_DUT_LO] == DEVICE_ADDR);
  wire [4:0]  cmd_addr  = cmd[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire        cmd_read  = cmd_ok & cmd[`CMD_RW_BIT];
  wire        cmd_write = cmd_ok & ~cmd[`CMD_RW_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and readback selection

  reg        read_pend_r;
  reg [4:0]  read_addr_r;
  reg        status_sent_r;
  reg [23:0] tx_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      main_ctrl_r <= `MAIN_CTRL_RESET;
      toggle_r    <= `SOFT_RESET;
      read_pend_r <= 1'b0;
      read_addr_r <= 5'h00;
    end else if (frame_end) begin
      read_pend_r <= cmd_read;
      if (cmd_read) begin
        read_addr_r <= cmd_addr;
      end
      if (cmd_write && cmd_addr == `WR_MAIN_CTRL) begin
        main_ctrl_r <= cmd[15:0];
      end
      if (cmd_write && cmd_addr == `WR_SOFTWARE) begin
        toggle_r <= cmd[`SOFT_TOGGLE_BIT];
      end
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      status_on_write_enable <= 1'b0;
    end else begin
      status_on_write_enable <= main_ctrl_r[`MAIN_STATUS_ON_WRITE_ENABLE_BIT];
    end
  end

  reg [15:0] read_data;

  always @* begin
    case (read_addr_r)
      `RD_STATUS:    read_data = status_word;
      `RD_MAIN_CTRL: read_data = main_ctrl_r;
      default:       read_data = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial transmit

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_r          <= 24'h000000;
      status_sent_r <= 1'b0;
      sdo           <= 1'b0;
    end else if (frame_start) begin
      // pending read served in the next transfer
      if (read_pend_r) begin
        tx_r          <= {3'b000, read_addr_r, read_data};
        status_sent_r <= (read_addr_r == `RD_STATUS);
        sdo           <= 1'b0;
      // status-on-write enabled: status shifted out in every frame with no pending read
      end else if (main_ctrl_r[`MAIN_STATUS_ON_WRITE_ENABLE_BIT]) begin
        tx_r          <= {8'h00, status_word};
        status_sent_r <= 1'b1;
        sdo           <= 1'b0;
      end else begin
        tx_r          <= 24'h000000;
        status_sent_r <= 1'b0;
        sdo           <= 1'b0;
      end
    end else if (sclk_rise) begin
      tx_r <= {tx_r[22:0], 1'b0};
      sdo  <= tx_r[23];
    end else if (frame_end) begin
      sdo <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet error flag and fault pin

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pec_err_r <= 1'b0;
    end else if (pec_fail) begin
      // A new failure wins over the clear by a read
      pec_err_r <= 1'b1;
    // cleared once status has been read
    end else if (frame_end && status_sent_r) begin
      pec_err_r <= 1'b0;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_out <= 1'b0;
      fault_oe  <= 1'b0;
    end else begin
      fault_out <= 1'b0;
      fault_oe  <= (|loop_bits) | pec_err_r | overheat_s;
    end
  end

endmodule

/* fault_status_props.sv */
`timescale 1ns/100ps
module fault_status_props (
  input wire       clock,
  input wire       rst,
  input wire       sclk,
  input wire       sync_n,
  input wire       sdin,
  input wire       sdo,
  input wire [3:0] loop_fault,
  input wire [3:0] boost_limit_flag,
  input wire       overheat,
  input wire       slew_active,
  input wire       fault_out,
  input wire       fault_oe,
  input wire       status_on_write_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire any_src = overheat | (|loop_fault) | (|boost_limit_flag);
  fault_drive_low_a: assert property (fault_out == 1'b0)
    else $error("fault pin driven high");
  overheat_fault_a: assert property (overheat [*5] |-> fault_oe)
    else $error("overheat did not pull fault low");
  loop_fault_a: assert property ((|loop_fault) [*5] |-> fault_oe)
    else $error("loop fault did not pull fault low");
  boost_fault_a: assert property ((|boost_limit_flag) [*5] |-> fault_oe)
    else $error("boost limit did not pull fault low");
  fault_cause_a: assert property ($rose(fault_oe) |-> $past(sync_n) || $past(any_src, 3))
    else $error("fault raised without cause");
  fault_release_a: assert property ($fell(fault_oe) |-> !$past(any_src, 3))
    else $error("fault released with source present");
  idle_sdo_a: assert property (sync_n [*6] |-> !sdo)
    else $error("sdo active outside frame");
  sdo_on_sclk_a: assert property ($changed(sdo) |-> $past(sclk, 2))
    else $error("sdo moved while sclk low");
  enable_frame_a: assert property ($changed(status_on_write_enable) |-> $past(sync_n, 2))
    else $error("enable changed inside frame");
endmodule
bind fault_status_reporting fault_status_props i_props (.clock(clock), .rst(rst), .sclk(sclk),
  .sync_n(sync_n), .sdin(sdin), .sdo(sdo), .loop_fault(loop_fault),
  .boost_limit_flag(boost_limit_flag), .overheat(overheat), .slew_active(slew_active),
  .fault_out(fault_out), .fault_oe(fault_oe), .status_on_write_enable(status_on_write_enable));

/* spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
  input  wire clock,
  input  wire sdo,
  output reg  sclk,
  output reg  sync_n,
  output reg  sdin
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  task xfer(input [31:0] w, input integer nb, output [23:0] r);
    integer i;
    begin
      r = 24'h000000;
      @(posedge clock);
      #1;
      sync_n = 1'b0;
      #400;
      for (i = nb - 1; i >= 0; i = i - 1) begin
        sclk = 1'b0;
        sdin = w[i];
        #400;
        sclk = 1'b1;
        #400;
        if (i >= nb - 24)
          r[24 - nb + i] = sdo;
      end
      sync_n = 1'b1;
      // Released data line must not look like a held bit
      sdin = ~sdin;
      #1200;
    end
  endtask
endmodule

/* fault_status_reporting_tb_top.sv */
`timescale 1ns/100ps
module fault_status_reporting_tb_top;
  reg         clock, rst, overheat, slew_active, tgl;
  reg  [3:0]  loop_fault, boost_limit_flag;
  wire        sclk, sync_n, sdin, sdo, fault_out, fault_oe, status_on_write_enable;
  integer     n_errors, checked, cyc, k;
  reg  [23:0] r;
  wire        fault_line = fault_oe ? 1'b0 : 1'b1;
  fault_status_reporting i_dut (.clock(clock), .rst(rst), .sclk(sclk), .sync_n(sync_n),
    .sdin(sdin), .sdo(sdo), .loop_fault(loop_fault), .boost_limit_flag(boost_limit_flag),
    .overheat(overheat), .slew_active(slew_active), .fault_out(fault_out),
    .fault_oe(fault_oe), .status_on_write_enable(status_on_write_enable));
  spi_host_model i_host (.clock(clock), .sdo(sdo), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input [23:0] seen, input [23:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  function [15:0] st(input pec);
    st = {boost_limit_flag, tgl, pec, slew_active, overheat, 4'h0, loop_fault | boost_limit_flag};
  endfunction
  function [7:0] crc8(input [23:0] d);
    integer i;
    begin
      crc8 = 8'h00;
      for (i = 23; i >= 0; i = i - 1)
        crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
  endfunction
  task rd_status(input pec);
    begin
      i_host.xfer(32'h00980000, 24, r);
      i_host.xfer(32'h001CE000, 24, r);
      check(r, {8'h18, st(pec)});
      // The no-operation frame writes the software register with the toggle clear
      tgl = 1'b0;
    end
  endtask
  task set_src(input o, input [3:0] b, input [3:0] l);
    begin
      @(posedge clock);
      #1;
      overheat = o;
      boost_limit_flag = b;
      loop_fault = l;
      repeat (6) @(posedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_sources;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        set_src(k == 0, {1'b0, k == 1, 2'b00}, {2'b00, k == 2, 1'b0});
        check(fault_line, 1'b0);
        set_src(1'b0, 4'h0, 4'h0);
        check(fault_line, 1'b1);
      end
      #1;
      slew_active = 1'b1;
      set_src(1'b1, 4'h8, 4'h1);
      rd_status(1'b0);
      slew_active = 1'b0;
      set_src(1'b0, 4'h0, 4'h0);
    end
  endtask
  task t_toggle_ro;
    begin
      i_host.xfer(32'h001C1000, 24, r);
      tgl = 1'b1;
      i_host.xfer(32'h0018FFFF, 24, r);
      rd_status(1'b0);
    end
  endtask
  task t_pec;
    begin
      i_host.xfer({24'h1C0000, crc8(24'h1C0000) ^ 8'h01}, 32, r);
      check(fault_line, 1'b0);
      rd_status(1'b1);
      rd_status(1'b0);
      check(fault_line, 1'b1);
      i_host.xfer({24'h1C1000, crc8(24'h1C1000)}, 32, r);
      tgl = 1'b1;
      check(fault_line, 1'b1);
      rd_status(1'b0);
    end
  endtask
  task t_status_on_write_enable;
    begin
      check(status_on_write_enable, 1'b0);
      i_host.xfer(32'h00191000, 24, r);
      check(status_on_write_enable, 1'b1);
      i_host.xfer(32'h001C0000, 24, r);
      check(r, {8'h00, st(1'b0)});
      i_host.xfer(32'h00990000, 24, r);
      i_host.xfer(32'h001CE000, 24, r);
      check(r, {8'h19, 16'h1000});
    end
  endtask
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {overheat, slew_active, tgl, loop_fault, boost_limit_flag} = 11'h000;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    repeat (12) @(posedge clock);
    #1;
    check({sdo, fault_out, fault_oe, status_on_write_enable}, 4'h0);
    rst = 1'b0;
    repeat (3) @(posedge clock);
    t_sources;
    t_toggle_ro;
    t_pec;
    t_status_on_write_enable;
    report_and_stop;
  end
endmodule
